// [common/pvm_pkg.sv]
/*
 * constants for the upper-index phy management register bank:
 * register indices, field positions, reset values and mode encodings.
 * assumes a 50 MHz management-side clock.
 */
`default_nettype none
package pvm_pkg;

	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [4:0] PVM_IDX_SPECIAL_MODES    = 5'h12;
	localparam logic [4:0] PVM_IDX_SPECIAL_CTRL     = 5'h1B;
	localparam logic [4:0] PVM_IDX_IRQ_SOURCE       = 5'h1D;
	localparam logic [4:0] PVM_IDX_IRQ_MASK         = 5'h1E;
	localparam logic [4:0] PVM_IDX_NEG_STATUS       = 5'h1F;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PVM_MODE_LSB      = 5;
	localparam int PVM_REF_LOCK_BIT  = 10;
	localparam int PVM_POLARITY_BIT  = 4;
	localparam int PVM_AN_DONE_BIT   = 12;
	localparam int PVM_SPEED_LSB     = 2;
	localparam int PVM_NEG_RSVD_LSB  = 5;

	// ------------------------------------------------------------
	// reset and fixed values
	// ------------------------------------------------------------
	localparam logic [4:0] PVM_ADDR_RESET     = 5'h01;
	localparam logic [3:0] PVM_CTRL_FIXED     = 4'hB;
	localparam logic [6:0] PVM_NEG_RSVD_RESET = 7'h02;
	localparam logic [7:0] PVM_MASK_RESET     = 8'h00;
	localparam logic [7:0] PVM_FLAGS_RESET    = 8'h00;

	// ------------------------------------------------------------
	// operating modes
	// ------------------------------------------------------------
	localparam logic [2:0] PVM_MODE_10_HALF   = 3'h0;
	localparam logic [2:0] PVM_MODE_10_FULL   = 3'h1;
	localparam logic [2:0] PVM_MODE_100_HALF  = 3'h2;
	localparam logic [2:0] PVM_MODE_100_FULL  = 3'h3;
	localparam logic [2:0] PVM_MODE_AN_100H   = 3'h4;
	localparam logic [2:0] PVM_MODE_REPEATER  = 3'h5;
	localparam logic [2:0] PVM_MODE_RESERVED  = 3'h6;
	localparam logic [2:0] PVM_MODE_ALL       = 3'h7;

	// control defaults are bits [13,12,10,8] of the basic control reg
	localparam logic [3:0] PVM_CTL_10_HALF  = 4'h0;
	localparam logic [3:0] PVM_CTL_10_FULL  = 4'h1;
	localparam logic [3:0] PVM_CTL_100_HALF = 4'h8;
	localparam logic [3:0] PVM_CTL_100_FULL = 4'h9;
	localparam logic [3:0] PVM_CTL_AN_100H  = 4'hC;
	localparam logic [3:0] PVM_CTL_ALL      = 4'hD;
	// advertisement defaults are bits [8,7,6,5] of the advert reg
	localparam logic [3:0] PVM_ADV_NONE     = 4'h0;
	localparam logic [3:0] PVM_ADV_100H     = 4'h4;
	localparam logic [3:0] PVM_ADV_ALL      = 4'hF;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int PVM_CLK_HZ          = 50_000_000;
	localparam int PVM_ENERGY_QUIET_MS = 256;
	localparam int PVM_ENERGY_QUIET_CYC =
		(PVM_CLK_HZ / 1000) * PVM_ENERGY_QUIET_MS;

endpackage
`default_nettype wire

// [rtl/pvm_regs.sv]
/*
 * upper-index management registers of the integrated 10/100 phy:
 * special modes, special control, interrupt source flags, interrupt
 * mask and negotiation status, plus the line-energy quiet timer.
 * assumes the management frame decoder delivers one-cycle read and
 * write strobes with phy address, register index and data, and that
 * the phy datapath event pulses and levels are on the same clock.
 */
// Contract
// - three-bit read-write mode field in bits 7:5 of special modes
// - modes 000/001 force 10M half/full, control defaults 0000/0001
// - mode 010 forces 100 half, default 1000, carrier sense tx+rx
// - mode 011 forces 100 full, default 1001, carrier sense rx only
// - mode 100 negotiates 100 half only, defaults 1100 and 0100
// - mode 101 repeater, negotiation on, 100 half, carrier sense rx
// - mode 111 negotiates everything, advertisement default 1111
// - answer only at five-bit management address, reset 00001
// - bit 10 keeps the 10M receive pll on reference, blocks 10M rx
// - read-only bit 4 shows reversed 10M receive polarity
// - control bits 3:0 read 1011 and ignore writes
// - flags 7..4: energy, negotiation done, remote fault, link down
// - flags 3..1: partner ack, parallel fault, page; others zero
// - eight-bit read-write mask, reset zero, one enables the source
// - bit 12 reads one only once negotiation has completed
// - bits 4-2 give resolved speed and duplex codes
// - energy present drops after 256 ms quiet, set by hw reset
`default_nettype none
module pvm_regs
	import pvm_pkg::*;
#(
	parameter logic [2:0] MODE_RESET = PVM_MODE_ALL,
	parameter int         QUIET_CYC  = PVM_ENERGY_QUIET_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// management access
	input  wire logic        i_mgmt_rd,
	input  wire logic        i_mgmt_wr,
	input  wire logic [4:0]  i_mgmt_phy_addr,
	input  wire logic [4:0]  i_mgmt_reg_idx,
	input  wire logic [15:0] i_mgmt_wdata,
	output logic [15:0]      o_mgmt_rdata,
	output logic             o_mgmt_rd_valid,
	// phy datapath status and events
	input  wire logic        i_line_energy,
	input  wire logic        i_negotiation_done_evt,
	input  wire logic        i_remote_fault_evt,
	input  wire logic        i_link_down_evt,
	input  wire logic        i_partner_ack_evt,
	input  wire logic        i_parallel_fault_evt,
	input  wire logic        i_page_received_evt,
	input  wire logic        i_negotiation_done,
	input  wire logic        i_speed_100,
	input  wire logic        i_full_duplex,
	input  wire logic        i_polarity_reversed,
	// controls toward the phy
	output logic [2:0]       o_mode,
	output logic [4:0]       o_mgmt_bus_address,
	output logic [3:0]       o_ctrl_defaults,
	output logic [3:0]       o_adv_defaults,
	output logic             o_an_enable,
	output logic             o_repeater,
	output logic             o_crs_on_tx,
	output logic             o_rx_pll_ref_lock,
	output logic             o_energy_present,
	output logic             o_phy_irq
);

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	logic       addr_hit;
	logic       wr_mode, wr_ctrl, wr_mask, wr_neg, rd_src;
	logic [7:0] mode_rsvd_r;
	logic [2:0] mode_r;
	logic [4:0] addr_r;
	logic       ref_lock_r;
	logic [7:0] flags_r, flags_nxt, evt;
	logic [7:0] mask_r;
	logic [6:0] neg_rsvd_r;
	logic       energy_r, energy_prev_r;
	logic [23:0] quiet_cnt_r;

	function automatic logic idx_is(input logic [4:0] idx,
			input logic [4:0] want);
		idx_is = (idx == want);
	endfunction

	assign addr_hit = (i_mgmt_phy_addr == addr_r);
	assign wr_mode = i_mgmt_wr && addr_hit &&
		idx_is(i_mgmt_reg_idx, PVM_IDX_SPECIAL_MODES);
	assign wr_ctrl = i_mgmt_wr && addr_hit &&
		idx_is(i_mgmt_reg_idx, PVM_IDX_SPECIAL_CTRL);
	assign wr_mask = i_mgmt_wr && addr_hit &&
		idx_is(i_mgmt_reg_idx, PVM_IDX_IRQ_MASK);
	assign wr_neg = i_mgmt_wr && addr_hit &&
		idx_is(i_mgmt_reg_idx, PVM_IDX_NEG_STATUS);
	assign rd_src = i_mgmt_rd && addr_hit &&
		idx_is(i_mgmt_reg_idx, PVM_IDX_IRQ_SOURCE);

	// ------------------------------------------------------------
	// special modes
	// ------------------------------------------------------------
	// mode field storage
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_r      <= MODE_RESET;
			addr_r      <= PVM_ADDR_RESET;
			mode_rsvd_r <= 8'h00;
		end else if (wr_mode) begin
			mode_r      <= i_mgmt_wdata[PVM_MODE_LSB +: 3];
			addr_r      <= i_mgmt_wdata[4:0];
			mode_rsvd_r <= i_mgmt_wdata[15:8];
		end
	end

	// reserved mode 110 is left to the manager; it decodes as all-off
	always_comb begin
		o_ctrl_defaults = PVM_CTL_10_HALF;
		o_adv_defaults  = PVM_ADV_NONE;
		o_an_enable     = 1'b0;
		o_repeater      = 1'b0;
		o_crs_on_tx     = 1'b0;
		case (mode_r)
			PVM_MODE_10_HALF: begin
				o_ctrl_defaults = PVM_CTL_10_HALF;
				o_crs_on_tx     = 1'b1;
			end
			PVM_MODE_10_FULL: begin
				o_ctrl_defaults = PVM_CTL_10_FULL;
			end
			PVM_MODE_100_HALF: begin
				o_ctrl_defaults = PVM_CTL_100_HALF;
				o_crs_on_tx     = 1'b1;
			end
			PVM_MODE_100_FULL: begin
				o_ctrl_defaults = PVM_CTL_100_FULL;
			end
			PVM_MODE_AN_100H: begin
				o_ctrl_defaults = PVM_CTL_AN_100H;
				o_adv_defaults  = PVM_ADV_100H;
				o_an_enable     = 1'b1;
				o_crs_on_tx     = 1'b1;
			end
			PVM_MODE_REPEATER: begin
				o_ctrl_defaults = PVM_CTL_AN_100H;
				o_adv_defaults  = PVM_ADV_100H;
				o_an_enable     = 1'b1;
				o_repeater      = 1'b1;
			end
			PVM_MODE_RESERVED: begin
				o_ctrl_defaults = PVM_CTL_10_HALF;
			end
			PVM_MODE_ALL: begin
				o_ctrl_defaults = PVM_CTL_ALL;
				o_adv_defaults  = PVM_ADV_ALL;
				o_an_enable     = 1'b1;
				o_crs_on_tx     = 1'b1;
			end
			default: begin
				o_ctrl_defaults = PVM_CTL_10_HALF;
			end
		endcase
	end

	// ------------------------------------------------------------
	// special control
	// ------------------------------------------------------------
	// reference lock bit
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ref_lock_r <= 1'b0;
		end else if (wr_ctrl) begin
			ref_lock_r <= i_mgmt_wdata[PVM_REF_LOCK_BIT];
		end
	end

	// ------------------------------------------------------------
	// energy timer
	// ------------------------------------------------------------
	// quiet timeout and hw reset set
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			energy_r    <= 1'b1;
			quiet_cnt_r <= 24'h000000;
		end else if (i_line_energy) begin
			energy_r    <= 1'b1;
			quiet_cnt_r <= 24'h000000;
		end else if (quiet_cnt_r >= 24'(QUIET_CYC - 1)) begin
			energy_r    <= 1'b0;
		end else begin
			quiet_cnt_r <= quiet_cnt_r + 24'h000001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			energy_prev_r <= 1'b1;
		end else begin
			energy_prev_r <= energy_r;
		end
	end

	// ------------------------------------------------------------
	// interrupt flags and mask
	// ------------------------------------------------------------
	// upper sources
	assign evt[7] = energy_r && !energy_prev_r;
	assign evt[6] = i_negotiation_done_evt;
	assign evt[5] = i_remote_fault_evt;
	assign evt[4] = i_link_down_evt;
	// lower sources, bit 0 never set
	assign evt[3] = i_partner_ack_evt;
	assign evt[2] = i_parallel_fault_evt;
	assign evt[1] = i_page_received_evt;
	assign evt[0] = 1'b0;

	always_comb begin
		flags_nxt = rd_src ? evt : (flags_r | evt);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flags_r <= PVM_FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mask_r <= PVM_MASK_RESET;
		end else if (wr_mask) begin
			mask_r <= i_mgmt_wdata[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			neg_rsvd_r <= PVM_NEG_RSVD_RESET;
		end else if (wr_neg) begin
			neg_rsvd_r <= i_mgmt_wdata[PVM_NEG_RSVD_LSB +: 7];
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	logic [15:0] rd_word;
	logic        rd_mapped;

	always_comb begin
		rd_word   = 16'h0000;
		rd_mapped = 1'b1;
		case (i_mgmt_reg_idx)
			PVM_IDX_SPECIAL_MODES: begin
				rd_word = {mode_rsvd_r, mode_r, addr_r};
			end
			PVM_IDX_SPECIAL_CTRL: begin
				rd_word[PVM_POLARITY_BIT] = i_polarity_reversed;
				rd_word[3:0] = PVM_CTRL_FIXED;
				rd_word[PVM_REF_LOCK_BIT] = ref_lock_r;
			end
			PVM_IDX_IRQ_SOURCE: begin
				rd_word[7:0] = flags_r;
			end
			PVM_IDX_IRQ_MASK: begin
				rd_word[7:0] = mask_r;
			end
			PVM_IDX_NEG_STATUS: begin
				rd_word[PVM_AN_DONE_BIT] = i_negotiation_done &&
					o_an_enable;
				rd_word[PVM_NEG_RSVD_LSB +: 7] = neg_rsvd_r;
				rd_word[PVM_SPEED_LSB +: 3] = {i_full_duplex,
					i_speed_100, !i_speed_100};
			end
			default: begin
				rd_mapped = 1'b0;
			end
		endcase
	end

	// read data is held until the next accepted read
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_mgmt_rdata    <= 16'h0000;
			o_mgmt_rd_valid <= 1'b0;
		end else begin
			o_mgmt_rd_valid <= i_mgmt_rd && addr_hit && rd_mapped;
			if (i_mgmt_rd && addr_hit && rd_mapped) begin
				o_mgmt_rdata <= rd_word;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_mode             = mode_r;
	assign o_mgmt_bus_address = addr_r;
	assign o_rx_pll_ref_lock  = ref_lock_r;
	assign o_energy_present   = energy_r;
	assign o_phy_irq          = |(flags_r & mask_r);

endmodule
`default_nettype wire

// [testbench/pvm_regs_checker.sv]
/* concurrent checks on the pvm_regs ports.
   assumes one clock and a synchronous active-high reset. */
`default_nettype none
module pvm_regs_checker
	import pvm_pkg::*;
#(
	parameter int QUIET_CYC = 20
) (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_mgmt_rd,
	input wire logic        i_mgmt_wr,
	input wire logic [4:0]  i_mgmt_phy_addr,
	input wire logic [4:0]  i_mgmt_reg_idx,
	input wire logic [15:0] i_mgmt_wdata,
	input wire logic [15:0] o_mgmt_rdata,
	input wire logic        o_mgmt_rd_valid,
	input wire logic        i_line_energy,
	input wire logic        i_negotiation_done,
	input wire logic        i_speed_100,
	input wire logic        i_full_duplex,
	input wire logic        i_polarity_reversed,
	input wire logic [2:0]  o_mode,
	input wire logic [4:0]  o_mgmt_bus_address,
	input wire logic [3:0]  o_ctrl_defaults,
	input wire logic [3:0]  o_adv_defaults,
	input wire logic        o_an_enable,
	input wire logic        o_repeater,
	input wire logic        o_crs_on_tx,
	input wire logic        o_rx_pll_ref_lock,
	input wire logic        o_energy_present
);
	// ----
	// mode tables, one nibble or bit per mode
	// ----
	localparam logic [31:0] CTL = 32'hD0CC_9810;
	localparam logic [31:0] ADV = 32'hF044_0000;
	localparam logic [7:0]  AN  = 8'hB0;
	localparam logic [7:0]  REP = 8'h20;
	localparam logic [7:0]  CRS = 8'h95;
	wire logic hit = i_mgmt_phy_addr == o_mgmt_bus_address;
	wire logic rd_ok = i_mgmt_rd && hit &&
		i_mgmt_reg_idx inside {5'h12, 5'h1B, 5'h1D, 5'h1E, 5'h1F};
	wire logic wr12 = i_mgmt_wr && hit && i_mgmt_reg_idx == 5'h12;
	wire logic wr1b = i_mgmt_wr && hit && i_mgmt_reg_idx == 5'h1B;
	wire logic [3:0] st = {i_negotiation_done && o_an_enable,
		i_full_duplex, i_speed_100, !i_speed_100};
	logic [15:0] quiet_r;
	// quiet time is counted here so the long window needs no repetition
	always_ff @(posedge i_clk) begin
		if (i_rst || i_line_energy)
			quiet_r <= 16'h0000;
		else if (quiet_r != 16'hFFFF)
			quiet_r <= quiet_r + 16'h0001;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_mode_defaults: assert property (
		o_ctrl_defaults == CTL[o_mode*4 +: 4] &&
		o_adv_defaults == ADV[o_mode*4 +: 4])
		else $error("mode defaults wrong");
	a_mode_flags: assert property (
		o_an_enable == AN[o_mode] && o_repeater == REP[o_mode] &&
		o_crs_on_tx == CRS[o_mode])
		else $error("mode flags wrong");
	a_mode_write: assert property (wr12 |=>
		o_mode == $past(i_mgmt_wdata[7:5]) &&
		o_mgmt_bus_address == $past(i_mgmt_wdata[4:0]))
		else $error("mode write lost");
	a_mode_hold: assert property (!wr12 |=>
		$stable(o_mode) && $stable(o_mgmt_bus_address))
		else $error("mode changed unasked");
	a_read_answer: assert property (rd_ok |=> o_mgmt_rd_valid)
		else $error("read not answered");
	a_no_answer: assert property (!rd_ok |=> !o_mgmt_rd_valid)
		else $error("stray read answer");
	a_ref_lock: assert property (1 |=> o_rx_pll_ref_lock ==
		($past(wr1b) ? $past(i_mgmt_wdata[10]) :
		$past(o_rx_pll_ref_lock)))
		else $error("ref lock wrong");
	a_ctrl_read: assert property (
		rd_ok && i_mgmt_reg_idx == 5'h1B |=>
		o_mgmt_rdata[4:0] == {$past(i_polarity_reversed), 4'hB})
		else $error("control read wrong");
	a_flag_zero: assert property (rd_ok && i_mgmt_reg_idx == 5'h1D
		|=> o_mgmt_rdata[15:8] == 8'h00 && !o_mgmt_rdata[0])
		else $error("flag spare bits set");
	a_status_read: assert property (
		rd_ok && i_mgmt_reg_idx == 5'h1F |=>
		{o_mgmt_rdata[12], o_mgmt_rdata[4:2]} == $past(st))
		else $error("status read wrong");
	a_energy_drop: assert property (
		quiet_r > QUIET_CYC + 2 |-> !o_energy_present)
		else $error("energy kept too long");
	a_energy_hold: assert property (
		$fell(o_energy_present) |-> quiet_r >= QUIET_CYC - 2)
		else $error("energy dropped early");
endmodule
bind pvm_regs pvm_regs_checker #(.QUIET_CYC(QUIET_CYC)) u_chk (.*);
`default_nettype wire

// [testbench/pvm_mgmt_mac.sv]
/* management-side master standing in for the mac's frame decoder.
   assumes requests start one step after a rising clock edge. */
`default_nettype none
module pvm_mgmt_mac (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_rd_valid,
	output logic             o_rd,
	output logic             o_wr,
	output logic [4:0]       o_phy_addr,
	output logic [4:0]       o_reg_idx,
	output logic [15:0]      o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_phy_addr = 5'h00;
		o_reg_idx = 5'h00;
		o_wdata = 16'h0000;
	end
	// one strobe cycle; answer is taken one step after the accept edge
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [4:0] r, input logic [15:0] d,
		output logic v, output logic [15:0] q);
		@(posedge i_clk);
		#1;
		o_rd = !w;
		o_wr = w;
		o_phy_addr = a;
		o_reg_idx = r;
		o_wdata = d;
		@(posedge i_clk);
		#1;
		o_rd = 1'b0;
		o_wr = 1'b0;
		// idle data and index lines never keep the last value, so nothing leans on them; the phy address is left as it was
		o_wdata = ~d;
		o_reg_idx = ~r;
		v = i_rd_valid;
		q = i_rdata;
	endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
/* self-checking bench for pvm_regs through the management strobes.
   assumes pvm_pkg, the checker and the master model are compiled. */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int QUIET = 20;
	localparam logic [31:0] CTL = 32'hD0CC_9810;
	localparam logic [31:0] ADV = 32'hF044_0000;
	localparam logic [7:0]  AN  = 8'hB0;
	localparam logic [7:0]  REP = 8'h20;
	localparam logic [7:0]  CRS = 8'h95;
	logic        clk, rst, nrg, nd, s100, fd, pol, v, rd, wr, rdv, pres;
	logic        an, rep, crs, lck, irq;
	logic [5:0]  evt;
	logic [4:0]  pa, pad, idx, bad;
	logic [2:0]  mode;
	logic [3:0]  ctd, add;
	logic [15:0] q, wd, rdat;
	int          num_errors = 0, checked = 0, cyc = 0;
	pvm_mgmt_mac mac (.i_clk(clk), .i_rdata(rdat), .i_rd_valid(rdv),
		.o_rd(rd), .o_wr(wr), .o_phy_addr(pad), .o_reg_idx(idx),
		.o_wdata(wd));
	pvm_regs #(.QUIET_CYC(QUIET)) dut (.i_clk(clk), .i_rst(rst),
		.i_mgmt_rd(rd), .i_mgmt_wr(wr), .i_mgmt_phy_addr(pad),
		.i_mgmt_reg_idx(idx), .i_mgmt_wdata(wd), .o_mgmt_rdata(rdat),
		.o_mgmt_rd_valid(rdv), .i_line_energy(nrg),
		.i_negotiation_done_evt(evt[5]), .i_remote_fault_evt(evt[4]),
		.i_link_down_evt(evt[3]), .i_partner_ack_evt(evt[2]),
		.i_parallel_fault_evt(evt[1]), .i_page_received_evt(evt[0]),
		.i_negotiation_done(nd), .i_speed_100(s100),
		.i_full_duplex(fd), .i_polarity_reversed(pol), .o_mode(mode),
		.o_mgmt_bus_address(bad), .o_ctrl_defaults(ctd),
		.o_adv_defaults(add), .o_an_enable(an), .o_repeater(rep),
		.o_crs_on_tx(crs), .o_rx_pll_ref_lock(lck),
		.o_energy_present(pres), .o_phy_irq(irq));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ----
	// helpers
	// ----
	task automatic give_verdict;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdr(input logic [4:0] r, input logic [15:0] e);
		mac.xfer(1'b0, pa, r, 16'h0000, v, q);
		chk("rd_valid", 16'h0001, {15'h0, v});
		chk("rdata", e, q);
	endtask
	task automatic wrr(input logic [4:0] r, input logic [15:0] d);
		mac.xfer(1'b1, pa, r, d, v, q);
	endtask
	task automatic pulse(input logic [5:0] e);
		evt = e;
		@(posedge clk);
		#1 evt = 6'h00;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// a hang costs one mismatch and still reaches the verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			$display("timeout");
			give_verdict();
		end
	end
	initial begin
		{rst, nrg, nd, s100, fd, pol} = 6'b110000;
		{evt, pa} = {6'h00, 5'h01};
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		rdr(5'h12, 16'h00E1);
		rdr(5'h1B, 16'h000B);
		rdr(5'h1D, 16'h0000);
		rdr(5'h1E, 16'h0000);
		rdr(5'h1F, 16'h0044);
		$display("test reset done");
		for (int m = 0; m < 8; m++) begin
			if (m == 6)
				continue;
			wrr(5'h12, {8'h00, m[2:0], 5'h01});
			chk("mode", {2'b00, CTL[m*4 +: 4], ADV[m*4 +: 4], AN[m], REP[m],
				CRS[m], m[2:0]}, {2'b00, ctd, add, an, rep, crs, mode});
		end
		$display("test modes done");
		wrr(5'h12, 16'h00EA);
		mac.xfer(1'b0, 5'h01, 5'h12, 16'h0000, v, q);
		chk("old address", 16'h0000, {15'h0, v});
		pa = 5'h0A;
		rdr(5'h12, 16'h00EA);
		chk("bus address", 16'h000A, {11'h000, bad});
		mac.xfer(1'b0, pa, 5'h05, 16'h0000, v, q);
		chk("unmapped", 16'h0000, {15'h0, v});
		$display("test address done");
		wrr(5'h1B, 16'hFFFF);
		pol = 1'b1;
		rdr(5'h1B, 16'h041B);
		chk("ref lock", 16'h0001, {15'h0, lck});
		wrr(5'h1B, 16'h0000);
		pol = 1'b0;
		rdr(5'h1B, 16'h000B);
		$display("test control done");
		wrr(5'h1E, 16'hFFFF);
		rdr(5'h1E, 16'h00FF);
		chk("irq idle", 16'h0000, {15'h0, irq});
		nrg = 1'b0;
		repeat (QUIET + 4) @(posedge clk);
		#1 chk("energy off", 16'h0000, {15'h0, pres});
		nrg = 1'b1;
		pulse(6'h3F);
		chk("energy on", 16'h0001, {15'h0, pres});
		chk("irq set", 16'h0001, {15'h0, irq});
		rdr(5'h1D, 16'h00FE);
		rdr(5'h1D, 16'h0000);
		chk("irq clear", 16'h0000, {15'h0, irq});
		wrr(5'h1E, 16'h0000);
		pulse(6'h08);
		chk("irq masked", 16'h0000, {15'h0, irq});
		rdr(5'h1D, 16'h0010);
		$display("test flags done");
		{nd, s100, fd} = 3'b111;
		wrr(5'h1F, 16'h0040);
		rdr(5'h1F, 16'h1058);
		wrr(5'h12, 16'h006A);
		s100 = 1'b0;
		rdr(5'h1F, 16'h0054);
		{s100, fd} = 2'b10;
		rdr(5'h1F, 16'h0048);
		$display("test status done");
		give_verdict();
	end
endmodule
`default_nettype wire
